// [verilog/module_bus_pkg.sv]
package module_bus_pkg;
    // bus widths
    localparam int ADDR_W = 4;  // module address bus width
    localparam int DATA_W = 8;  // module data bus width
    localparam int SEL_W = 4;  // self-test selector width
    localparam int LVL_W = 8;  // digitised level and dac code width
    localparam int NUM_IN = 16;  // self-test selector inputs
    // control latch field positions
    localparam int CTL_NOISE = 0;  // noise source enable
    localparam int CTL_RFAMP = 1;  // rf amplifier switched in
    localparam int CTL_MUTE = 2;  // mute request
    localparam int CTL_TEST = 3;  // self-test mode, suppresses rf mute except from overload
    localparam int CTL_SEL_LO = 4;  // selector field low bit
    localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;  // latch after reset
    // status word fields
    localparam int STS_MUTE = 0;  // mute status bit
    localparam int STS_ID_LO = 1;  // identification code low bit
    localparam logic [ADDR_W-1:0] IDLE_ADDR = 4'h0;  // address while idle
    localparam logic [DATA_W-1:0] BUS_IDLE = 8'hff;  // pulled-up data bus
    // host register offsets
    localparam logic [7:0] OFS_SLOT = 8'h00;  // target slot code
    localparam logic [7:0] OFS_WDATA = 8'h04;  // write data
    localparam logic [7:0] OFS_DAC = 8'h08;  // dac code, 10 mV steps
    localparam logic [7:0] OFS_CMD = 8'h0c;  // bit0 go, bit1 read
    localparam logic [7:0] OFS_STATUS = 8'h10;  // bit0 busy, bit1 comparator
    localparam logic [7:0] OFS_RDATA = 8'h14;  // last read word
    localparam int CMD_GO = 0;  // command start bit
    localparam int CMD_READ = 1;  // command direction bit
    // strobe timing, least times
    localparam int CLK_PERIOD_PS = 5000;  // 200 MHz
    localparam int SETUP_NS = 20;  // address and data before strobe
    localparam int STROBE_NS = 50;  // strobe width
    localparam int READ_NS = 60;  // read access time
    localparam int HOLD_NS = 20;  // hold after strobe or read
    localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_CYC = (READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CYC = (HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 5;  // phase counter width
    // host sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_RWAIT = 5'b01000,
        ST_HOLD = 5'b10000
    } host_state_e;
endpackage : module_bus_pkg

// [verilog/module_bus_if.sv]
`timescale 1ns/1ps
interface module_bus_if;
    logic [module_bus_pkg::ADDR_W-1:0] addr;  // module address bus
    logic rw_read;  // high for read, low for write
    logic strobe;  // write strobe
    logic [module_bus_pkg::DATA_W-1:0] h_data_o;  // processor data drive
    logic h_data_oe;  // processor drives data
    logic [module_bus_pkg::DATA_W-1:0] d_data_o;  // module data drive
    logic d_data_oe;  // module drives data
    logic [module_bus_pkg::DATA_W-1:0] data;  // resolved data bus
    logic [module_bus_pkg::LVL_W-1:0] dac;  // processor dac code
    logic cmp_out;  // comparator result
    // resolved level, pulled up when nobody drives
    assign data = d_data_oe ? d_data_o : (h_data_oe ? h_data_o : module_bus_pkg::BUS_IDLE);
    modport dev (
        input addr,
        input rw_read,
        input strobe,
        input data,
        input dac,
        output d_data_o,
        output d_data_oe,
        output cmp_out
    );
    modport host (
        output addr,
        output rw_read,
        output strobe,
        output h_data_o,
        output h_data_oe,
        output dac,
        input data,
        input cmp_out
    );
endinterface : module_bus_if

// [verilog/selftest_level_comparator.sv]
`timescale 1ns/1ps
module selftest_level_comparator #(
    parameter int NUM = module_bus_pkg::NUM_IN,
    parameter int SW = module_bus_pkg::SEL_W,
    parameter int LW = module_bus_pkg::LVL_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM*LW-1:0] levels,
    input wire logic [SW-1:0] sel,
    input wire logic [LW-1:0] dac,
    output logic above_q
);
    logic [NUM*LW-1:0] lvl_s1_q;  // first stage, read only by second
    logic [NUM*LW-1:0] lvl_s2_q;  // synchronised levels
    logic [LW-1:0] picked;  // selected level

    // two-stage synchroniser for the monitored levels
    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_s1_q <= '0;
            lvl_s2_q <= '0;
        end else begin
            lvl_s1_q <= levels;
            lvl_s2_q <= lvl_s1_q;
        end
    end

    // selector picks one monitored level
    assign picked = lvl_s2_q[sel*LW +: LW];

    // high while the level exceeds the dac voltage
    always_ff @(posedge clk) begin
        if (rst) begin
            above_q <= 1'b0;
        end else begin
            above_q <= (picked > dac);
        end
    end
endmodule : selftest_level_comparator

// [verilog/front_end_bus_port.sv]
`timescale 1ns/1ps
// Behaviour
// - respond only when address equals slot code
// - matched access gives read or write pulse
// - write pulse timed from active strobe
// - drive data only during read pulse
// - read word holds id and mute
// - write pulse loads control latch outputs
// - selected input compared against processor dac
// - processor brackets level with two dac limits
// - hardware check: max dac, reference, expect low
// - rail checks step through rail inputs
// - checks run continuously and on demand
// - self-test: noise on, relay muted, rf unmuted unless overload; here NOISE_EN follows only CTL_NOISE, the test bit does not set it
// - processor mute request mutes module
module front_end_bus_port #(
    parameter logic [module_bus_pkg::ADDR_W-1:0] SLOT_CODE = 4'h3,
    parameter logic [6:0] ID_CODE = 7'h2a  // arbitrary identification value
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    module_bus_if.dev BUS,
    input wire logic OVERLOAD_DET,
    input wire logic HW_MUTE,
    input wire logic [module_bus_pkg::NUM_IN*module_bus_pkg::LVL_W-1:0] LEVELS,
    output logic NOISE_EN,
    output logic RF_AMP_IN,
    output logic ANT_RELAY_MUTE,
    output logic RF_MUTE,
    output logic [module_bus_pkg::SEL_W-1:0] MUX_SEL
);
    localparam int AW = module_bus_pkg::ADDR_W;  // address width
    localparam int DW = module_bus_pkg::DATA_W;  // data width
    localparam int LW = module_bus_pkg::LVL_W;  // dac width
    localparam int SW = module_bus_pkg::SEL_W;  // selector width
    localparam int IN_W = AW + 2 + DW + LW + 2;  // synchronised bundle width
    // pins cross domains here; the host
    // sets bits up well before the strobe,
    // so bundle skew is harmless

    // synchroniser stages for every pin from the processor
    logic [IN_W-1:0] pin_s1_q;  // first stage, read only by second
    logic [IN_W-1:0] pin_s2_q;  // second stage, safe to use

    logic [AW-1:0] addr_s;  // synchronised address
    logic rw_read_s;  // synchronised direction
    logic stb_s;  // synchronised strobe
    logic [DW-1:0] data_s;  // synchronised data bus
    logic [LW-1:0] dac_s;  // synchronised dac code
    logic ovl_s;  // synchronised overload
    logic hwm_s;  // synchronised rear-panel mute
    logic stb_prev_q;  // strobe one cycle ago

    // decode
    logic match;  // slot code matches
    logic rd_pulse;  // read access in progress
    logic wr_pulse;  // one-cycle write pulse

    // control latch and mute
    logic [DW-1:0] ctl_q;  // control latch
    logic ext_mute;  // mute sources other than self-test

    logic [DW-1:0] status_word;  // word returned on read
    logic dout_oe_q;  // data bus drive enable
    logic [DW-1:0] dout_q;  // data bus drive value
    logic cmp_q;  // comparator result

    // two flip-flops on every pin before any logic
    // stage one feeds stage two only
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {BUS.addr, BUS.rw_read, BUS.strobe,
                         BUS.data, BUS.dac,
                         OVERLOAD_DET, HW_MUTE};
            pin_s2_q <= pin_s1_q;
        end
    end

    // unpack the synchronised bundle
    // order matches the pack above
    assign {addr_s, rw_read_s, stb_s, data_s,
            dac_s, ovl_s, hwm_s} = pin_s2_q;

    // strobe history for edge detection
    // resets to the idle level, so
    // no false edge follows reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            stb_prev_q <= 1'b0;
        end else begin
            stb_prev_q <= stb_s;
        end
    end

    // slot decoder compares against the hardwired code
    // slot 0 is the idle address
    assign match = (addr_s == SLOT_CODE);
    // read pulse while a matched read is presented
    // lasts while the host holds it
    assign rd_pulse = match & rw_read_s;
    // write pulse on the rising strobe of a matched write
    // one cycle wide
    assign wr_pulse = match & ~rw_read_s
                      & stb_s & ~stb_prev_q;

    // control latch loads only on a write pulse
    // a long strobe loads once;
    // data is long settled by then
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ctl_q <= module_bus_pkg::CTL_RESET;
        end else if (wr_pulse) begin
            ctl_q <= data_s;
        end
        // otherwise hold the previous setting
    end

    // processor, overload and rear-panel mute sources
    // any one source mutes
    assign ext_mute = ctl_q[module_bus_pkg::CTL_MUTE]
                      | ovl_s | hwm_s;

    // status word: id code above the mute bit
    // mute bit covers both paths
    assign status_word = {ID_CODE, ANT_RELAY_MUTE | RF_MUTE};

    // drive the data bus only during a read pulse
    // enable and word share an edge;
    // idle line floats to its pull-up,
    // never to a stale word
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            dout_oe_q <= 1'b0;
            dout_q <= '0;
        end else begin
            dout_oe_q <= rd_pulse;
            dout_q <= rd_pulse ? status_word : '0;
        end
    end

    // latch outputs to the analog sections
    // one flop per output pin
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            NOISE_EN <= 1'b0;
            RF_AMP_IN <= 1'b0;
            MUX_SEL <= '0;
        end else begin
            NOISE_EN <= ctl_q[module_bus_pkg::CTL_NOISE];
            RF_AMP_IN <= ctl_q[module_bus_pkg::CTL_RFAMP];
            MUX_SEL <= ctl_q[module_bus_pkg::CTL_SEL_LO +: SW];
        end
    end

    // mute control: relay always follows, rf mute off in self-test
    // overload keeps rf muted even in
    // self-test, guarding the mixer
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ANT_RELAY_MUTE <= 1'b0;
            RF_MUTE <= 1'b0;
        end else begin
            // self-test mutes the relay so only injected noise enters
            ANT_RELAY_MUTE <= ext_mute
                              | ctl_q[module_bus_pkg::CTL_TEST];
            // overload still mutes rf; other sources yield to self-test
            RF_MUTE <= ovl_s
                       | (ext_mute & ~ctl_q[module_bus_pkg::CTL_TEST]);
        end
    end

    // selector and comparator against the processor dac
    // result lags dac changes by 3
    // cycles, selector changes by 1;
    // selector also feeds MUX_SEL
    selftest_level_comparator #(
        .NUM(module_bus_pkg::NUM_IN),
        .SW(SW),
        .LW(LW)
    ) u_cmp (
        .clk(SYS_CLK),
        .rst(RST),
        .levels(LEVELS),
        .sel(ctl_q[module_bus_pkg::CTL_SEL_LO +: SW]),
        .dac(dac_s),
        .above_q(cmp_q)
    );

    // bus-side outputs straight from flip-flops
    // host syncs cmp before use
    assign BUS.d_data_o = dout_q;
    assign BUS.d_data_oe = dout_oe_q;
    assign BUS.cmp_out = cmp_q;
endmodule : front_end_bus_port

// [verilog/processor_bus_master.sv]
`timescale 1ns/1ps
module processor_bus_master (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    module_bus_if.host BUS
);
    localparam int DW = module_bus_pkg::DATA_W;  // data width
    localparam int CW = module_bus_pkg::CNT_W;  // counter width

    module_bus_pkg::host_state_e state_q;  // sequencer state
    logic [CW-1:0] cnt_q;  // phase counter
    logic [module_bus_pkg::ADDR_W-1:0] slot_q;  // target slot
    logic [DW-1:0] wdata_q;  // word to write
    logic [module_bus_pkg::LVL_W-1:0] dac_q;  // dac code
    logic [DW-1:0] rdata_q;  // last word read
    logic is_read_q;  // current access is a read
    logic [DW+1-1:0] in_s1_q;  // first stage, read only by second
    logic [DW+1-1:0] in_s2_q;  // synchronised data and comparator
    logic acc;  // apb access phase
    logic wr_go;  // command register start
    logic busy;  // sequencer active

    assign acc = PSEL & PENABLE;
    assign busy = (state_q != module_bus_pkg::ST_IDLE);
    assign wr_go = acc & PREADY & PWRITE & (PADDR == module_bus_pkg::OFS_CMD)
                   & PWDATA[module_bus_pkg::CMD_GO];

    // synchronise the bus data and comparator result
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            in_s1_q <= '0;
            in_s2_q <= '0;
        end else begin
            in_s1_q <= {BUS.data, BUS.cmp_out};
            in_s2_q <= in_s1_q;
        end
    end

    // apb slave: ready one cycle into the access phase
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else if (acc & ~PREADY) begin
            PREADY <= 1'b1;
            PSLVERR <= 1'b0;
            PRDATA <= '0;
            if (PADDR == module_bus_pkg::OFS_SLOT) begin
                PRDATA <= {28'h000_0000, slot_q};
            end else if (PADDR == module_bus_pkg::OFS_WDATA) begin
                PRDATA <= {24'h00_0000, wdata_q};
            end else if (PADDR == module_bus_pkg::OFS_DAC) begin
                PRDATA <= {24'h00_0000, dac_q};
            end else if (PADDR == module_bus_pkg::OFS_CMD) begin
                PRDATA <= '0;
            end else if (PADDR == module_bus_pkg::OFS_STATUS) begin
                PRDATA <= {30'h0000_0000, in_s2_q[0], busy};
            end else if (PADDR == module_bus_pkg::OFS_RDATA) begin
                PRDATA <= {24'h00_0000, rdata_q};
            end else begin
                PSLVERR <= 1'b1;  // unmapped offset
            end
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // register writes take effect at the completing edge
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            slot_q <= module_bus_pkg::IDLE_ADDR;
            wdata_q <= '0;
            dac_q <= '0;
        end else if (acc & PREADY & PWRITE) begin
            if (PADDR == module_bus_pkg::OFS_SLOT) begin
                slot_q <= PWDATA[module_bus_pkg::ADDR_W-1:0];
            end else if (PADDR == module_bus_pkg::OFS_WDATA) begin
                wdata_q <= PWDATA[DW-1:0];
            end else if (PADDR == module_bus_pkg::OFS_DAC) begin
                dac_q <= PWDATA[module_bus_pkg::LVL_W-1:0];
            end
        end
    end

    // access sequencer; a start while busy is ignored
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_q <= module_bus_pkg::ST_IDLE;
            cnt_q <= '0;
            is_read_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            case (state_q)
                module_bus_pkg::ST_IDLE: begin
                    if (wr_go) begin
                        is_read_q <= PWDATA[module_bus_pkg::CMD_READ];
                        cnt_q <= CW'(module_bus_pkg::SETUP_CYC - 1);
                        state_q <= module_bus_pkg::ST_SETUP;
                    end
                end
                module_bus_pkg::ST_SETUP: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (is_read_q) begin
                        cnt_q <= CW'(module_bus_pkg::READ_CYC - 1);
                        state_q <= module_bus_pkg::ST_RWAIT;
                    end else begin
                        cnt_q <= CW'(module_bus_pkg::STROBE_CYC - 1);
                        state_q <= module_bus_pkg::ST_STROBE;
                    end
                end
                module_bus_pkg::ST_STROBE: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        cnt_q <= CW'(module_bus_pkg::HOLD_CYC - 1);
                        state_q <= module_bus_pkg::ST_HOLD;
                    end
                end
                module_bus_pkg::ST_RWAIT: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        rdata_q <= in_s2_q[DW:1];
                        cnt_q <= CW'(module_bus_pkg::HOLD_CYC - 1);
                        state_q <= module_bus_pkg::ST_HOLD;
                    end
                end
                module_bus_pkg::ST_HOLD: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= module_bus_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= module_bus_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // bus pins driven from state-derived flip-flops
    logic [module_bus_pkg::ADDR_W-1:0] addr_q;  // address pins
    logic rw_q;  // direction pin
    logic stb_q;  // strobe pin
    logic doe_q;  // data drive enable
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            addr_q <= module_bus_pkg::IDLE_ADDR;
            rw_q <= 1'b1;
            stb_q <= 1'b0;
            doe_q <= 1'b0;
        end else begin
            addr_q <= busy ? slot_q : module_bus_pkg::IDLE_ADDR;
            rw_q <= busy ? is_read_q : 1'b1;
            stb_q <= (state_q == module_bus_pkg::ST_STROBE);
            doe_q <= busy & ~is_read_q;
        end
    end
    assign BUS.addr = addr_q;
    assign BUS.rw_read = rw_q;
    assign BUS.strobe = stb_q;
    assign BUS.h_data_o = wdata_q;
    assign BUS.h_data_oe = doe_q;
    assign BUS.dac = dac_q;
endmodule : processor_bus_master

// [bench/module_bus_chk.sv]
`timescale 1ns/1ps
module module_bus_chk #(
    parameter logic [module_bus_pkg::ADDR_W-1:0] SLOT_CODE = 4'h3,
    parameter logic [6:0] ID_CODE = 7'h2a  // arbitrary identification value
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [module_bus_pkg::ADDR_W-1:0] addr,
    input wire logic rw_read,
    input wire logic strobe,
    input wire logic h_data_oe,
    input wire logic [module_bus_pkg::DATA_W-1:0] d_data_o,
    input wire logic d_data_oe
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic rd_sel;  // read access aimed at this slot
    assign rd_sel = (addr == SLOT_CODE) && rw_read;
    // nine more high cycles after the first, a ten-cycle strobe, then low
    sequence strobe_rest_s;
        strobe[*8] ##1 strobe ##1 !strobe;
    endsequence
    // host keeps address and data through the hold phase
    sequence hold_s;
        (h_data_oe && $stable(addr))[*3];
    endsequence
    drive_cause_a: assert property (d_data_oe |-> $past(rd_sel, 3))
        else $error("module drives data without a matching read");
    drive_soon_a: assert property (rd_sel[*4] |-> d_data_oe)
        else $error("matching read not answered in time");
    read_id_a: assert property (d_data_oe |-> d_data_o[7:1] == ID_CODE)
        else $error("read word lacks identification code");
    no_contend_a: assert property (!(h_data_oe && d_data_oe))
        else $error("both ends drive the data bus");
    strobe_write_a: assert property (strobe |-> !rw_read && h_data_oe)
        else $error("strobe outside a write access");
    strobe_width_a: assert property ($rose(strobe) |=> strobe_rest_s)
        else $error("strobe width wrong");
    strobe_setup_a: assert property ($rose(strobe) |->
        $past(h_data_oe, 3) && ($past(addr, 3) == addr))
        else $error("write data not set up before strobe");
    strobe_hold_a: assert property ($fell(strobe) |-> hold_s)
        else $error("write data released too early after strobe");
endmodule : module_bus_chk

// [bench/module_bus_slave_with_selftest_mux_tb.sv]
`timescale 1ns/1ps
module module_bus_slave_with_selftest_mux_tb;
    logic sys_clk = 1'b0;  // 200 MHz
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic overload = 1'b0;  // rf overload level
    logic hw_mute = 1'b0;  // rear-panel mute level
    logic [127:0] levels = {16{8'h00}};  // digitised self-test levels
    logic noise_en;
    logic rf_amp_in;
    logic relay_mute;
    logic rf_mute;
    logic [3:0] mux_sel;
    int failures = 0;
    int checks = 0;
    // clock
    always #2.5 sys_clk = ~sys_clk;
    module_bus_if i_module_bus_if ();
    front_end_bus_port i_front_end_bus_port (.SYS_CLK(sys_clk), .RST(rst),
        .BUS(i_module_bus_if), .OVERLOAD_DET(overload), .HW_MUTE(hw_mute), .LEVELS(levels),
        .NOISE_EN(noise_en), .RF_AMP_IN(rf_amp_in), .ANT_RELAY_MUTE(relay_mute),
        .RF_MUTE(rf_mute), .MUX_SEL(mux_sel));
    processor_bus_master i_processor_bus_master (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .BUS(i_module_bus_if));
    module_bus_chk i_module_bus_chk (.SYS_CLK(sys_clk), .RST(rst),
        .addr(i_module_bus_if.addr), .rw_read(i_module_bus_if.rw_read),
        .strobe(i_module_bus_if.strobe), .h_data_oe(i_module_bus_if.h_data_oe),
        .d_data_o(i_module_bus_if.d_data_o), .d_data_oe(i_module_bus_if.d_data_oe));
    // count and report one comparison
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 100) begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 100) check("pready", 32'h0000_0001, 32'h0000_0000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, wd, rd, e);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] rd);
        logic e;
        apb(1'b0, a, 32'h0000_0000, rd, e);
    endtask : reg_rd
    // one module bus access, waits for busy to drop
    task automatic mod_op(input logic rd_op, input logic [3:0] slot, input logic [7:0] wd,
                          output logic [7:0] rdw);
        logic [31:0] v;
        int n;
        reg_wr(module_bus_pkg::OFS_SLOT, {28'h000_0000, slot});
        reg_wr(module_bus_pkg::OFS_WDATA, {24'h00_0000, wd});
        reg_wr(module_bus_pkg::OFS_CMD, {30'h0000_0000, rd_op, 1'b1});
        v = 32'h0000_0001;
        n = 0;
        while (v[0] !== 1'b0 && n < 50) begin
            reg_rd(module_bus_pkg::OFS_STATUS, v);
            n++;
        end
        if (v[0] !== 1'b0) check("busy", 32'h0000_0000, v);
        reg_rd(module_bus_pkg::OFS_RDATA, v);
        rdw = v[7:0];
    endtask : mod_op
    // expected {selector, rf mute, relay mute, rf amp, noise} from latch and mute inputs
    function automatic logic [7:0] exp_out(input logic [7:0] l, input logic ov, input logic hw);
        logic relay;
        logic rfm;
        relay = l[2] | ov | hw | l[3];
        rfm = ov | ((l[2] | hw) & ~l[3]);
        return {l[7:4], rfm, relay, l[1], l[0]};
    endfunction : exp_out
    task automatic chk_out(input logic [7:0] exp);
        check("controls", {24'h00_0000, exp}, {24'h00_0000, mux_sel, rf_mute, relay_mute,
              rf_amp_in, noise_en});
    endtask : chk_out
    // reset state and a refused apb offset
    task automatic t_reset();
        logic [31:0] rd;
        logic e;
        chk_out(8'h00);
        check("data drive", 32'h0000_0000, {31'h0000_0000, i_module_bus_if.d_data_oe});
        apb(1'b0, 8'h20, 32'h0000_0000, rd, e);
        check("slverr", 32'h0000_0001, {31'h0000_0000, e});
    endtask : t_reset
    // latch patterns written, outputs and status word checked
    task automatic t_latch();
        logic [7:0] tbl [5] = '{8'ha3, 8'h04, 8'h0d, 8'h18, 8'h5c};
        logic [7:0] r;
        logic [7:0] x;
        foreach (tbl[i]) begin
            mod_op(1'b0, 4'h3, tbl[i], r);
            x = exp_out(tbl[i], 1'b0, 1'b0);
            chk_out(x);
            mod_op(1'b1, 4'h3, 8'h00, r);
            check("read word", {24'h00_0000, 7'h2a, x[3] | x[2]}, {24'h00_0000, r});
        end
    endtask : t_latch
    // other slots neither drive nor load
    task automatic t_foreign();
        logic [7:0] r;
        mod_op(1'b0, 4'h5, 8'hff, r);
        mod_op(1'b0, 4'h2, 8'h01, r);
        chk_out(exp_out(8'h5c, 1'b0, 1'b0));
        mod_op(1'b1, 4'h4, 8'h00, r);
        check("foreign read", {24'h00_0000, module_bus_pkg::BUS_IDLE}, {24'h00_0000, r});
    endtask : t_foreign
    // mute sources against self-test mode
    task automatic t_mute();
        logic [7:0] tbl [3] = '{8'h0d, 8'h04, 8'h00};
        logic [7:0] r;
        foreach (tbl[i]) begin
            mod_op(1'b0, 4'h3, tbl[i], r);
            for (int k = 0; k < 4; k++) begin
                overload <= k[0];
                hw_mute <= k[1];
                repeat (8) @(posedge sys_clk);
                chk_out(exp_out(tbl[i], k[0], k[1]));
            end
        end
    endtask : t_mute
    // select an input, set the dac, look at the comparator
    task automatic cmp_at(input logic [3:0] sel, input logic [7:0] dac, input logic exp);
        logic [7:0] r;
        logic [31:0] v;
        mod_op(1'b0, 4'h3, {sel, 4'h0}, r);
        check("selector", {28'h000_0000, sel}, {28'h000_0000, mux_sel});
        reg_wr(module_bus_pkg::OFS_DAC, {24'h00_0000, dac});
        repeat (10) @(posedge sys_clk);
        reg_rd(module_bus_pkg::OFS_STATUS, v);
        check("comparator", {31'h0000_0000, exp}, {31'h0000_0000, v[1]});
    endtask : cmp_at
    // hardware check, then two-limit window on every rail input
    task automatic t_compare();
        @(posedge sys_clk);
        levels[15:8] <= 8'hfa;
        for (int i = 2; i < 7; i++) levels[i*8+:8] <= 8'h80 + 8'(i * 8);
        cmp_at(4'h1, 8'hff, 1'b0);
        cmp_at(4'h1, 8'hf9, 1'b1);
        for (int i = 2; i < 7; i++) begin
            cmp_at(4'(i), 8'h7f + 8'(i * 8), 1'b1);
            cmp_at(4'(i), 8'h80 + 8'(i * 8), 1'b0);
        end
        cmp_at(4'h1, 8'hff, 1'b0);
    endtask : t_compare
    // counts, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge sys_clk);
        check("watchdog", 32'h0000_0001, 32'h0000_0000);
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_latch();
        t_foreign();
        t_mute();
        t_compare();
        give_verdict();
    end
endmodule : module_bus_slave_with_selftest_mux_tb
